// [hw/led_pat_consts.svh]
// Constants for the two-channel status indicator pattern generator.
`ifndef LED_PAT_CONSTS_SVH
`define LED_PAT_CONSTS_SVH

// Register indices and byte addresses (index times four).
`define IDX_CHAN_A   16'h404c
`define IDX_CHAN_B   16'h404d
`define ADDR_CHAN_A  {14'h0000, `IDX_CHAN_A, 2'h0}
`define ADDR_CHAN_B  {14'h0000, `IDX_CHAN_B, 2'h0}
`define HSIZE_WORD   3'h2

// Field positions, reset value and writable bits of a control register.
`define F_SRC        15:14
`define F_MODE       9:8
`define F_LEN        5:4
`define F_DUR        3:2
`define F_DUTY       1:0
`define REG_RESET    16'hc026
`define REG_WMASK    16'hc33f

// Timing base: the always-on slow clock and the printed on times.
`define SLOW_HZ      64'd32768
`define ON_1S_US     64'd1000000
`define ON_250_US    64'd250000
`define ON_125_US    64'd125000
`define ON_MIN_US    64'd62500
`define US_PER_S     64'd1000000
`define BASE_TICKS   ((`ON_MIN_US * `SLOW_HZ) / `US_PER_S)

// Off-time multiples and burst lengths.
`define RATIO_0      3'd1
`define RATIO_1      3'd2
`define RATIO_2      3'd3
`define RATIO_3      3'd7
`define BURST_0      3'd1
`define BURST_1      3'd2
`define BURST_2      3'd4
`define BURST_3      3'd7
`define TIMER_W      20

`endif

// [hw/led_pat_pkg.sv]
// Types shared by the status indicator pattern generator.
package led_pat_pkg;
  `include "led_pat_consts.svh"

  typedef enum logic [1:0] {SRC_OFF, SRC_PWR, SRC_RSVD, SRC_MAN} src_e;
  typedef enum logic [1:0] {PAT_OFF, PAT_CONST, PAT_CONT, PAT_BURST} pattern_e;
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_ON = 2'h1, ST_OFF = 2'h3, ST_DONE = 2'h2} chan_state_e;
  typedef logic [`TIMER_W-1:0] timer_t;

  typedef struct packed {
    chan_state_e st;
    timer_t      timer;
    logic [2:0]  pulses;
    logic        led;
  } chan_s;

  typedef struct packed {
    logic       write;
    logic [1:0] hit;
  } dphase_s;

  typedef struct packed {
    logic [1:0][15:0] ctl;
    dphase_s          dp;
    logic [31:0]      rdata;
    chan_s [1:0]      ch;
  } top_s;

  typedef struct packed {
    logic [2:0] ff;
    logic       level;
    logic       tick;
  } sync_s;
endpackage

// [hw/slow_tick_sync.sv]
// Synchroniser for the always-on slow clock pin, giving one tick per rising edge.
`timescale 1ns/1ns
module slow_tick_sync
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Slow clock pin and tick
  input  wire logic slow_clk_pin,
  output logic      tick
);
  import led_pat_pkg::*;

  sync_s s;
  sync_s next_s;

  // A change is accepted only once the second and third stages agree, so a
  // metastable first stage never reaches the tick logic.
  always_comb
  begin
    next_s      = s;
    next_s.ff   = {s.ff[1:0], slow_clk_pin};
    next_s.tick = 1'b0;
    if (s.ff[1] == s.ff[2] && s.ff[2] != s.level)
    begin
      next_s.level = s.ff[2];
      next_s.tick  = s.ff[2]; // R11
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign tick = s.tick;

  property p_tick_edge;
    @(posedge core_clk) disable iff (!rst_n)
    s.tick |-> s.level && !$past(s.level);
  endproperty
  a_tick_edge: assert property (p_tick_edge) else $error("tick without a slow clock rise"); // R11
endmodule

// [hw/status_indicator_pattern_gen.sv]
// Two status indicator channels with an AHB-Lite register slave.
//
// Functional notes
// [R1] The source field picks off, power-state status or manual mode, with code 10 reserved.
// [R2] Two identical channels each own a control register of source, mode, length, on and duty.
// [R3] The mode field acts only while the source selects manual mode.
// [R4] In manual mode the pattern is off, constant, endless pulsing or a finite burst.
// [R5] The burst length field gives one, two, four or seven pulses.
// [R6] The on-time field gives one second, 250 ms, 125 ms or 62.5 ms of on time per pulse.
// [R7] The duty field makes the off time one, two, three or seven times the on time.
// [R8] Channel one also lights when automatic memory programming has finished.
// [R9] Channel two also lights when automatic memory programming has failed.
// [R10] After reset each register holds source 11, mode 00, length 10, on time 01, duty 10.
// [R11] The reserved source keeps the output off, and pulse timing counts the slow clock.
// [R12] A finished burst stays dark until the register is rewritten, which restarts it.
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ns
`include "led_pat_consts.svh"
module status_indicator_pattern_gen
#(
  parameter int unsigned BASE_TICKS = 32'(`BASE_TICKS)
)
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Slow always-on clock pin
  input  wire logic        slow_clk_pin,
  // Status inputs from core logic
  input  wire logic        power_state_on,
  input  wire logic        otp_prog_done,
  input  wire logic        otp_prog_error,
  // Indicator outputs
  output logic             chan_a_led,
  output logic             chan_b_led
);
  import led_pat_pkg::*;

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------
  localparam longint unsigned MAX_SPAN = longint'(BASE_TICKS) * 64'd16 * 64'd7;

  generate
    if (BASE_TICKS < 1 || MAX_SPAN >= (64'd1 << `TIMER_W))
    begin : g_bad_base
      $error("BASE_TICKS does not fit the pulse timer");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  function automatic logic [1:0] reg_hit(input logic [31:0] addr);
    reg_hit = {addr == `ADDR_CHAN_B, addr == `ADDR_CHAN_A};
  endfunction

  function automatic src_e src_of(input logic [15:0] r);
    src_of = src_e'(r[`F_SRC]);
  endfunction

  function automatic pattern_e pat_of(input logic [15:0] r);
    pat_of = pattern_e'(r[`F_MODE]);
  endfunction

  function automatic timer_t on_ticks(input logic [15:0] r);
    logic [63:0] us;
    us = `ON_1S_US;
    case (r[`F_DUR])
      2'h0: us = `ON_1S_US;
      2'h1: us = `ON_250_US;
      2'h2: us = `ON_125_US;
      default: us = `ON_MIN_US;
    endcase
    on_ticks = timer_t'(64'(BASE_TICKS) * (us / `ON_MIN_US)); // R6
  endfunction

  function automatic timer_t off_ticks(input logic [15:0] r);
    logic [2:0] mult;
    mult = `RATIO_0;
    case (r[`F_DUTY])
      2'h0: mult = `RATIO_0;
      2'h1: mult = `RATIO_1;
      2'h2: mult = `RATIO_2;
      default: mult = `RATIO_3;
    endcase
    off_ticks = timer_t'(on_ticks(r) * mult); // R7
  endfunction

  function automatic logic [2:0] burst_n(input logic [15:0] r);
    burst_n = `BURST_0;
    case (r[`F_LEN])
      2'h0: burst_n = `BURST_0;
      2'h1: burst_n = `BURST_1;
      2'h2: burst_n = `BURST_2;
      default: burst_n = `BURST_3;
    endcase
  endfunction

  function automatic logic pulsing(input logic [15:0] r);
    pulsing = src_of(r) == SRC_MAN && (pat_of(r) == PAT_CONT || pat_of(r) == PAT_BURST);
  endfunction

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------------
  // Slow clock tick
  // ----------------------------------------------------------------------
  logic tick;

  slow_tick_sync u_tick
  (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .slow_clk_pin (slow_clk_pin),
    .tick         (tick)
  );

  // ----------------------------------------------------------------------
  // Register slave and channel sequencers
  // ----------------------------------------------------------------------
  top_s       s;
  top_s       next_s;
  logic [1:0] restart;
  logic [1:0] otp_flag;
  logic [1:0] pattern_on;

  assign otp_flag = {otp_prog_error, otp_prog_done}; // R8 R9

  always_comb
  begin
    next_s     = s;
    restart    = 2'h0;
    pattern_on = 2'h0;

    // Data phase of a write. Sub-word writes are ignored.
    for (int i = 0; i < 2; i++)
    begin
      if (s.dp.write && s.dp.hit[i])
      begin
        next_s.ctl[i] = hwdata[15:0] & `REG_WMASK; // R2
        restart[i]    = 1'b1; // R12
      end
    end

    // Address phase. Read data comes from next_s so that a read right after a
    // write to the same register returns the new value.
    if (hready)
    begin
      next_s.dp = '0;
      if (hsel && htrans[1])
      begin
        next_s.dp.write = hwrite && hsize == `HSIZE_WORD;
        next_s.dp.hit   = reg_hit(haddr);
        if (!hwrite)
        begin
          next_s.rdata = 32'h0000_0000;
          for (int i = 0; i < 2; i++)
          begin
            if (next_s.dp.hit[i])
              next_s.rdata = {16'h0000, next_s.ctl[i]};
          end
        end
      end
    end

    // Channel sequencers. The first on period may be up to one slow tick
    // short, since the burst starts on the core clock, not on a tick.
    for (int i = 0; i < 2; i++)
    begin
      if (!pulsing(s.ctl[i]) || restart[i])
      begin
        next_s.ch[i].st     = ST_IDLE;
        next_s.ch[i].timer  = '0;
        next_s.ch[i].pulses = 3'h0;
      end
      else
      begin
        case (s.ch[i].st)
          ST_IDLE:
          begin
            next_s.ch[i].st    = ST_ON;
            next_s.ch[i].timer = '0;
          end
          ST_ON:
          begin
            if (tick)
            begin
              if (s.ch[i].timer == on_ticks(s.ctl[i]) - timer_t'(1)) // R6
              begin
                next_s.ch[i].timer = '0;
                next_s.ch[i].st    = ST_OFF;
                if (pat_of(s.ctl[i]) == PAT_BURST)
                begin
                  next_s.ch[i].pulses = s.ch[i].pulses + 3'h1;
                  if (s.ch[i].pulses + 3'h1 == burst_n(s.ctl[i])) // R5
                    next_s.ch[i].st = ST_DONE; // R12
                end
              end
              else
              begin
                next_s.ch[i].timer = s.ch[i].timer + timer_t'(1);
              end
            end
          end
          ST_OFF:
          begin
            if (tick)
            begin
              if (s.ch[i].timer == off_ticks(s.ctl[i]) - timer_t'(1)) // R7
              begin
                next_s.ch[i].timer = '0;
                next_s.ch[i].st    = ST_ON;
              end
              else
              begin
                next_s.ch[i].timer = s.ch[i].timer + timer_t'(1);
              end
            end
          end
          ST_DONE:
          begin
            next_s.ch[i].st = ST_DONE; // R12
          end
          default:
          begin
            next_s.ch[i].st = ST_IDLE;
          end
        endcase
      end

      // Output selection; the mode field is looked at only in manual mode.
      case (src_of(s.ctl[i])) // R1
        SRC_OFF:  pattern_on[i] = 1'b0;
        SRC_PWR:  pattern_on[i] = power_state_on; // R3
        SRC_MAN:
        begin
          case (pat_of(s.ctl[i])) // R4
            PAT_OFF:   pattern_on[i] = 1'b0;
            PAT_CONST: pattern_on[i] = 1'b1;
            default:   pattern_on[i] = next_s.ch[i].st == ST_ON;
          endcase
        end
        default:  pattern_on[i] = 1'b0; // R11
      endcase
      next_s.ch[i].led = otp_flag[i] | pattern_on[i]; // R8 R9
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s     <= '0;
      s.ctl <= {2{`REG_RESET}}; // R10
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = s.rdata;
  assign chan_a_led = s.ch[0].led;
  assign chan_b_led = s.ch[1].led;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_reg_write;
    @(posedge core_clk) disable iff (!rst_n)
    (s.dp.write && s.dp.hit[1]) |=> s.ctl[1] == ($past(hwdata[15:0]) & `REG_WMASK);
  endproperty
  a_reg_write: assert property (p_reg_write) else $error("register write lost"); // R2

  property p_reset_val;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(rst_n) |-> s.ctl[0] == `REG_RESET && s.ctl[1] == `REG_RESET && !chan_a_led && !chan_b_led;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("bad reset value"); // R10

  property p_src_off;
    @(posedge core_clk) disable iff (!rst_n)
    (src_of(s.ctl[0]) == SRC_OFF && !otp_prog_done) |=> !chan_a_led;
  endproperty
  a_src_off: assert property (p_src_off) else $error("off source lit channel one"); // R1

  property p_src_rsvd;
    @(posedge core_clk) disable iff (!rst_n)
    (src_of(s.ctl[1]) == SRC_RSVD && !otp_prog_error) |=> !chan_b_led;
  endproperty
  a_src_rsvd: assert property (p_src_rsvd) else $error("reserved source lit channel two"); // R11

  property p_pwr_follow;
    @(posedge core_clk) disable iff (!rst_n)
    (src_of(s.ctl[0]) == SRC_PWR && !otp_prog_done) |=> chan_a_led == $past(power_state_on);
  endproperty
  a_pwr_follow: assert property (p_pwr_follow) else $error("status source ignored"); // R3

  property p_constant;
    @(posedge core_clk) disable iff (!rst_n)
    (src_of(s.ctl[1]) == SRC_MAN && pat_of(s.ctl[1]) == PAT_CONST) |=> chan_b_led;
  endproperty
  a_constant: assert property (p_constant) else $error("constant pattern dark"); // R4

  property p_on_end;
    @(posedge core_clk) disable iff (!rst_n)
    (s.ch[0].st == ST_ON && tick && !restart[0] && pulsing(s.ctl[0])
      && s.ch[0].timer == on_ticks(s.ctl[0]) - timer_t'(1)) |=> s.ch[0].st != ST_ON;
  endproperty
  a_on_end: assert property (p_on_end) else $error("on time not ended"); // R6

  property p_off_end;
    @(posedge core_clk) disable iff (!rst_n)
    (s.ch[0].st == ST_OFF && tick && !restart[0] && pulsing(s.ctl[0])
      && s.ch[0].timer == off_ticks(s.ctl[0]) - timer_t'(1)) |=> s.ch[0].st == ST_ON;
  endproperty
  a_off_end: assert property (p_off_end) else $error("off time not ended"); // R7

  property p_burst_len;
    @(posedge core_clk) disable iff (!rst_n)
    s.ch[1].st == ST_DONE |-> s.ch[1].pulses == burst_n(s.ctl[1]);
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("wrong burst length"); // R5

  property p_done_dark;
    @(posedge core_clk) disable iff (!rst_n)
    (s.ch[0].st == ST_DONE && !s.dp.write && !otp_prog_done) |=> !chan_a_led;
  endproperty
  a_done_dark: assert property (p_done_dark) else $error("finished burst lit"); // R12

  property p_otp_done;
    @(posedge core_clk) disable iff (!rst_n)
    otp_prog_done |=> chan_a_led;
  endproperty
  a_otp_done: assert property (p_otp_done) else $error("programming done not shown"); // R8

  property p_otp_err;
    @(posedge core_clk) disable iff (!rst_n)
    otp_prog_error |=> chan_b_led;
  endproperty
  a_otp_err: assert property (p_otp_err) else $error("programming error not shown"); // R9
endmodule

// [dv/led_watch.sv]
// Model of the two indicator lamps and of the always-on slow clock source.
`timescale 1ns/1ns
module led_watch
(
  // Clocks
  input  wire logic             core_clk,
  output logic                  slow_clk_pin,
  // Lamp lines and measurements
  input  wire logic             clr,
  input  wire logic [1:0]       led,
  output logic [1:0][15:0]      rises,
  output logic [1:0][15:0]      on_len,
  output logic [1:0][15:0]      off_len
);
  logic [1:0]       led_q = '0;
  logic [1:0][15:0] run   = '0;

  // ----------------------------------------------------------------
  // Slow clock
  // ----------------------------------------------------------------
  // Eight core periods per slow period keeps every length an exact multiple.
  initial
  begin
    slow_clk_pin = 1'b0;
    #3;
    forever #40 slow_clk_pin = ~slow_clk_pin;
  end

  // ----------------------------------------------------------------
  // Lamp timing
  // ----------------------------------------------------------------
  // A run counts core cycles spent at one level, saved when the level flips.
  always_ff @(posedge core_clk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      led_q[i] <= led[i];
      run[i] <= (led[i] != led_q[i]) ? 16'h0001 : run[i] + 16'h0001;
      if (led[i] && !led_q[i])
        off_len[i] <= run[i];
      if (!led[i] && led_q[i])
        on_len[i] <= run[i];
      if (clr)
        rises[i] <= 16'h0000;
      else if (led[i] && !led_q[i])
        rises[i] <= rises[i] + 16'h0001;
    end
  end
endmodule

// [dv/status_indicator_pattern_gen_test.sv]
// Self-checking bench for the status indicator pattern generator.
`timescale 1ns/1ns
`include "led_pat_consts.svh"
module status_indicator_pattern_gen_test;
  localparam int BASE = 2;
  localparam int SLOW = 8;
  logic             core_clk;
  logic             rst_b;
  logic             hsel;
  logic             hwrite;
  logic [31:0]      haddr;
  logic [31:0]      hwdata;
  logic [31:0]      hrdata;
  logic [31:0]      rd;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic             hreadyout;
  logic             hresp;
  logic             slow_clk_pin;
  logic             clr;
  logic             pso;
  logic             done;
  logic             fail;
  logic [1:0]       led;
  logic [1:0][15:0] rises;
  logic [1:0][15:0] on_len;
  logic [1:0][15:0] off_len;
  int               n_errors;
  int               compares;
  int               on_mul [4]  = '{16, 4, 2, 1};
  int               off_mul [4] = '{1, 2, 3, 7};
  int               burst [4]   = '{1, 2, 4, 7};
  logic [15:0]      src_cfg [6] = '{16'h4000, 16'h4100, 16'h0100, 16'h8100, 16'hc100, 16'hc000};
  logic             src_pso [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  logic             src_exp [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};

  status_indicator_pattern_gen #(.BASE_TICKS(BASE)) dut
  (
    .core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .slow_clk_pin(slow_clk_pin),
    .power_state_on(pso), .otp_prog_done(done), .otp_prog_error(fail),
    .chan_a_led(led[0]), .chan_b_led(led[1])
  );

  led_watch lamps
  (
    .core_clk(core_clk), .slow_clk_pin(slow_clk_pin), .clr(clr), .led(led),
    .rises(rises), .on_len(on_len), .off_len(off_len)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic summarize;
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stall;
    n_errors++;
    $display("unexpected at %0t: wait ran out", $time);
    summarize();
  endtask

  task automatic wait_ready;
    int k;
    k = 0;
    @(posedge core_clk);
    while (hreadyout !== 1'b1)
    begin
      k++;
      if (k > 100)
        stall();
      @(posedge core_clk);
    end
  endtask

  // Called just after a rising edge; returns just after the data-phase edge.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= `HSIZE_WORD;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wreg(input logic [31:0] a, input logic [15:0] v);
    bus(1'b1, a, {16'h0000, v});
  endtask

  task automatic rreg(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Darkens both lamps before counting so old patterns add no rises.
  task automatic setup(input logic [15:0] v);
    wreg(`ADDR_CHAN_A, 16'hc000);
    wreg(`ADDR_CHAN_B, 16'hc000);
    clr <= 1'b1;
    cyc(2);
    clr <= 1'b0;
    wreg(`ADDR_CHAN_A, v);
    wreg(`ADDR_CHAN_B, v);
  endtask

  task automatic wait_rises(input int n);
    int k;
    k = 0;
    while (rises[0] < n || rises[1] < n)
    begin
      k++;
      if (k > 5000)
        stall();
      @(posedge core_clk);
    end
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    clr = 1'b1;
    pso = 1'b0;
    done = 1'b0;
    fail = 1'b0;
    n_errors = 0;
    compares = 0;
    cyc(5);
    rst_b <= 1'b1;
    clr <= 1'b0;
    cyc(3);
    chk({30'h0, led}, 32'h0);
    rreg(`ADDR_CHAN_A, {16'h0000, `REG_RESET});
    rreg(`ADDR_CHAN_B, {16'h0000, `REG_RESET});
    wreg(`ADDR_CHAN_B + 32'h4, 16'hffff);
    rreg(`ADDR_CHAN_B + 32'h4, 32'h0);
    wreg(`ADDR_CHAN_A, 16'hffff);
    rreg(`ADDR_CHAN_A, {16'h0000, `REG_WMASK});
    rreg(`ADDR_CHAN_B, {16'h0000, `REG_RESET});
    for (int i = 0; i < 6; i++)
    begin
      pso <= src_pso[i];
      wreg(`ADDR_CHAN_A, src_cfg[i]);
      wreg(`ADDR_CHAN_B, src_cfg[i]);
      cyc(4);
      chk({30'h0, led}, {30'h0, {2{src_exp[i]}}});
    end
    done <= 1'b1;
    cyc(4);
    chk({30'h0, led}, 32'h1);
    done <= 1'b0;
    fail <= 1'b1;
    cyc(4);
    chk({30'h0, led}, 32'h2);
    fail <= 1'b0;
    for (int d = 0; d < 4; d++)
    begin
      setup({8'hc2, 4'h0, d[1:0], d[1:0]});
      wait_rises(3);
      for (int c = 0; c < 2; c++)
      begin
        chk({16'h0, on_len[c]}, 32'(on_mul[d] * BASE * SLOW));
        chk({16'h0, off_len[c]}, 32'(on_mul[d] * off_mul[d] * BASE * SLOW));
      end
    end
    for (int l = 0; l < 4; l++)
    begin
      setup({8'hc3, 2'h0, l[1:0], 4'hc});
      cyc(700);
      chk({16'h0, rises[0]}, 32'(burst[l]));
      chk({16'h0, rises[1]}, 32'(burst[l]));
      chk({30'h0, led}, 32'h0);
    end
    summarize();
  end
endmodule
